// ==== rtl/comm_objects_defines.svh ====
// offsets, indices, reset values, error codes and timing counts of the communication objects
`ifndef COMM_OBJECTS_DEFINES_SVH
`define COMM_OBJECTS_DEFINES_SVH

// object indices
`define IDX_ERROR_HISTORY      16'h1003
`define IDX_SYNC_IDENTIFIER    16'h1005
`define IDX_SYNC_CYCLE_PERIOD  16'h1006
`define IDX_DEVICE_NAME        16'h1008
`define IDX_SOFTWARE_VERSION   16'h100a
`define IDX_GUARD_TIME_MS      16'h100c
`define IDX_LIFETIME_MULT      16'h100d

// error history layout
`define HIST_DEPTH             10
`define HIST_CODE_LSB          0
`define HIST_ERRREG_LSB        16
`define HIST_MODULE_LSB        24
`define HIST_MAX_MODULE        8'h0e

// reset values
`define RST_ERROR_COUNT        8'h00
`define RST_SYNC_IDENTIFIER    32'h0000_0080
`define RST_SYNC_CYCLE         32'h0000_0000
`define RST_GUARD_TIME         16'h0000
`define RST_LIFETIME_MULT      8'h00

// sync identifier fields
`define SYNC_GEN_BIT           30
`define SYNC_EXT_BIT           29
`define SYNC_ID_MSB            10

// cycle period limits, in microseconds
`define SYNC_CYCLE_MIN_US      32'd10000
`define SYNC_CYCLE_STEP_US     32'd1000
`define SYNC_CYCLE_MAX_US      32'd10000000

// timing: 1 ms at 10 MHz
`define CLK_PERIOD_NS          100
`define MS_IN_NS               1000000
`define CYCLES_PER_MS          (`MS_IN_NS / `CLK_PERIOD_NS)

// error codes
`define CODE_NO_ERROR                     16'h0000
`define CODE_ANALOG_IRQ_OFF               16'h0080
`define CODE_INTERNAL_COMM                16'h1000
`define CODE_RX_QUEUE_OVERRUN             16'h6101
`define CODE_TX_QUEUE_OVERRUN             16'h6102
`define CODE_LOCAL_BUS_CFG_TIMEOUT        16'h7001
`define CODE_LOCAL_BUS_CFG_MISMATCH       16'h7002
`define CODE_LOCAL_BUS_RUNTIME_FAULT      16'h7003
`define CODE_FRAME_LOST                   16'h8110
`define CODE_ERROR_PASSIVE                16'h8120
`define CODE_GUARD_MISSING                16'h8130
`define CODE_BUS_OFF_RECOVERED            16'h8140
`define CODE_PDO_SIZE_MISMATCH            16'h8210
`define CODE_RECEIVE_PDO_EXPIRY           16'h8250
`define CODE_SYNC_TIMEOUT                 16'hf001
`define CODE_COUPLER_UPDATE_FAIL          16'hff01
`define CODE_MODULE_UPDATE_FAIL           16'hff02
`define CODE_ADDRESS_SWITCH_CHANGED       16'hff03
`define CODE_UNCONFIGURED_OPERATIONAL     16'hff04

`endif

// ==== rtl/comm_objects_pkg.sv ====
// types shared by the communication object block
package comm_objects_pkg;

    // fault causes, one per error code
    typedef enum logic [4:0] {
        FAULT_CLEARED            = 5'h00,
        FAULT_ANALOG_IRQ_OFF     = 5'h01,
        FAULT_INTERNAL_COMM      = 5'h02,
        FAULT_RX_OVERRUN         = 5'h03,
        FAULT_TX_OVERRUN         = 5'h04,
        FAULT_CFG_TIMEOUT        = 5'h05,
        FAULT_CFG_MISMATCH       = 5'h06,
        FAULT_RUNTIME            = 5'h07,
        FAULT_FRAME_LOST         = 5'h08,
        FAULT_ERROR_PASSIVE      = 5'h09,
        FAULT_GUARD_MISSING      = 5'h0a,
        FAULT_BUS_OFF_RECOVERED  = 5'h0b,
        FAULT_PDO_SIZE           = 5'h0c,
        FAULT_RPDO_EXPIRY        = 5'h0d,
        FAULT_SYNC_TIMEOUT       = 5'h0e,
        FAULT_COUPLER_UPDATE     = 5'h0f,
        FAULT_MODULE_UPDATE      = 5'h10,
        FAULT_SWITCH_CHANGED     = 5'h11,
        FAULT_UNCONFIGURED_OP    = 5'h12
    } fault_cause_t;

    // one reported fault
    typedef struct packed {
        fault_cause_t cause;
        logic [7:0]   module_num;
        logic [7:0]   error_register;
    } fault_event_t;

    // one error history entry
    typedef struct packed {
        logic [7:0]  module_num;
        logic [7:0]  error_register;
        logic [15:0] code;
    } history_entry_t;

    // object dictionary access request
    typedef struct packed {
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub_index;
        logic [31:0] data;
    } od_request_t;

    // object dictionary access answer
    typedef struct packed {
        logic        abort;
        logic [31:0] data;
    } od_answer_t;

    // guarding supervision states, gray along idle-armed-expired
    typedef enum logic [1:0] {
        GUARD_IDLE    = 2'b00,
        GUARD_ARMED   = 2'b01,
        GUARD_EXPIRED = 2'b11
    } guard_state_t;

endpackage

// ==== rtl/comm_objects.sv ====
// communication object entries: error history, sync identifier and period, names, life guarding
`timescale 1ns/1ps
`include "comm_objects_defines.svh"

module comm_objects
    import comm_objects_pkg::*;
#(
    parameter int          DEPTH         = `HIST_DEPTH,
    parameter int          MS_CYCLES     = `CYCLES_PER_MS,
    parameter logic [63:0] NAME_STRING   = 64'h4e4f44455f583031, // arbitrary neutral value
    parameter logic [63:0] VERSION_STR   = 64'h30312e30302e3030  // "01.00.00", arbitrary
) (
    // clock and reset
    input  wire logic                           clk_in,
    input  wire logic                           resetn_in,
    input  wire logic                           clk_en_in,
    // fault reporting
    input  wire logic                           fault_valid_in,
    input  wire comm_objects_pkg::fault_event_t fault_in,
    // object dictionary access
    input  wire logic                           od_valid_in,
    input  wire comm_objects_pkg::od_request_t  od_req_in,
    output logic                                od_done_out,
    output comm_objects_pkg::od_answer_t        od_ans_out,
    // received frames
    input  wire logic                           frame_valid_in,
    input  wire logic [10:0]                    frame_id_in,
    output logic                                sync_hit_out,
    // life guarding
    input  wire logic                           guard_rx_in,
    output logic                                guard_expired_out,
    output logic [23:0]                         guard_timeout_ms_out,
    // sync period view
    output logic [31:0]                         sync_period_out
);
    import comm_objects_pkg::*;

    // refuse sizes that the 8-bit count and sub-index cannot serve
    if (DEPTH < 1 || DEPTH > 255) begin : g_bad_depth
        $error("DEPTH out of range");
    end
    // a zero prescaler would never produce a millisecond tick
    if (MS_CYCLES < 1) begin : g_bad_ms
        $error("MS_CYCLES must be at least 1");
    end

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------

    // cause to error code mapping
    function automatic logic [15:0] code_of(input fault_cause_t c);
        case (c)
            FAULT_CLEARED:           code_of = `CODE_NO_ERROR;
            FAULT_ANALOG_IRQ_OFF:    code_of = `CODE_ANALOG_IRQ_OFF;
            FAULT_INTERNAL_COMM:     code_of = `CODE_INTERNAL_COMM;
            FAULT_RX_OVERRUN:        code_of = `CODE_RX_QUEUE_OVERRUN;
            FAULT_TX_OVERRUN:        code_of = `CODE_TX_QUEUE_OVERRUN;
            FAULT_CFG_TIMEOUT:       code_of = `CODE_LOCAL_BUS_CFG_TIMEOUT;
            FAULT_CFG_MISMATCH:      code_of = `CODE_LOCAL_BUS_CFG_MISMATCH;
            FAULT_RUNTIME:           code_of = `CODE_LOCAL_BUS_RUNTIME_FAULT;
            FAULT_FRAME_LOST:        code_of = `CODE_FRAME_LOST;
            FAULT_ERROR_PASSIVE:     code_of = `CODE_ERROR_PASSIVE;
            FAULT_BUS_OFF_RECOVERED: code_of = `CODE_BUS_OFF_RECOVERED;
            FAULT_GUARD_MISSING:     code_of = `CODE_GUARD_MISSING;
            FAULT_PDO_SIZE:          code_of = `CODE_PDO_SIZE_MISMATCH;
            FAULT_RPDO_EXPIRY:       code_of = `CODE_RECEIVE_PDO_EXPIRY;
            FAULT_SYNC_TIMEOUT:      code_of = `CODE_SYNC_TIMEOUT;
            FAULT_COUPLER_UPDATE:    code_of = `CODE_COUPLER_UPDATE_FAIL;
            FAULT_MODULE_UPDATE:     code_of = `CODE_MODULE_UPDATE_FAIL;
            FAULT_SWITCH_CHANGED:    code_of = `CODE_ADDRESS_SWITCH_CHANGED;
            FAULT_UNCONFIGURED_OP:   code_of = `CODE_UNCONFIGURED_OPERATIONAL;
            default:                 code_of = `CODE_INTERNAL_COMM;
        endcase
    endfunction

    // legal sync identifier: no generation, no extended id, upper id bits zero
    function automatic logic sync_id_ok(input logic [31:0] v);
        sync_id_ok = (v[`SYNC_GEN_BIT] == 1'b0) && (v[`SYNC_EXT_BIT:`SYNC_ID_MSB+1] == '0);
    endfunction

    // legal period: zero, or 10 ms..10 s in whole milliseconds
    function automatic logic period_ok(input logic [31:0] v);
        period_ok = (v == 32'h0000_0000) ||
                    ((v >= `SYNC_CYCLE_MIN_US) && (v <= `SYNC_CYCLE_MAX_US) &&
                     ((v % `SYNC_CYCLE_STEP_US) == 32'h0000_0000));
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    history_entry_t hist_q [DEPTH];
    logic [7:0]     count_q;
    logic [31:0]    sync_id_q;
    logic [31:0]    sync_period_q;
    logic [15:0]    guard_time_q;
    logic [7:0]     lifetime_q;
    logic           od_done_q;
    od_answer_t     od_ans_q;
    logic           sync_hit_q;
    guard_state_t   guard_state_q;
    logic [23:0]    guard_ms_left_q;
    logic [31:0]    ms_tick_cnt_q;

    // ---------------------------------------------------------------
    // decode of object dictionary accesses
    // ---------------------------------------------------------------
    wire            od_wr       = od_valid_in && od_req_in.write;
    wire            is_hist     = od_req_in.index == `IDX_ERROR_HISTORY;
    wire            hist_sub0   = is_hist && (od_req_in.sub_index == 8'h00);
    wire            hist_entry  = is_hist && (od_req_in.sub_index != 8'h00) &&
                                  (od_req_in.sub_index <= 8'(DEPTH));
    wire            is_sync_id  = (od_req_in.index == `IDX_SYNC_IDENTIFIER) && (od_req_in.sub_index == 8'h00);
    wire            is_period   = (od_req_in.index == `IDX_SYNC_CYCLE_PERIOD) && (od_req_in.sub_index == 8'h00);
    wire            is_name     = (od_req_in.index == `IDX_DEVICE_NAME) && (od_req_in.sub_index == 8'h00);
    wire            is_version  = (od_req_in.index == `IDX_SOFTWARE_VERSION) && (od_req_in.sub_index == 8'h00);
    wire            is_guard    = (od_req_in.index == `IDX_GUARD_TIME_MS) && (od_req_in.sub_index == 8'h00);
    wire            is_life     = (od_req_in.index == `IDX_LIFETIME_MULT) && (od_req_in.sub_index == 8'h00);
    wire            clear_hist  = od_wr && hist_sub0 && (od_req_in.data == 32'h0000_0000);
    wire            wr_sync_id  = od_wr && is_sync_id && sync_id_ok(od_req_in.data);
    wire            wr_period   = od_wr && is_period && period_ok(od_req_in.data);
    wire            wr_guard    = od_wr && is_guard;
    wire            wr_life     = od_wr && is_life;
    wire            wr_ok       = clear_hist || wr_sync_id || wr_period || wr_guard || wr_life;
    wire [7:0]      hist_idx    = od_req_in.sub_index - 8'h01;

    // read data selection; the strings are returned as two 32-bit halves over sub-index 0 reads
    logic [31:0] rd_data;
    logic        rd_ok;
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        if (hist_sub0) begin
            rd_data = {24'h00_0000, count_q};
        end else if (hist_entry) begin
            rd_data = hist_q[hist_idx[$clog2(DEPTH+1)-1:0]];
        end else if (is_sync_id) begin
            rd_data = sync_id_q;
        end else if (is_period) begin
            rd_data = sync_period_q;
        end else if (is_name) begin
            rd_data = od_req_in.data[0] ? NAME_STRING[63:32] : NAME_STRING[31:0];
        end else if (is_version) begin
            rd_data = od_req_in.data[0] ? VERSION_STR[63:32] : VERSION_STR[31:0];
        end else if (is_guard) begin
            rd_data = {16'h0000, guard_time_q};
        end else if (is_life) begin
            rd_data = {24'h00_0000, lifetime_q};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // error history
    // ---------------------------------------------------------------
    history_entry_t new_entry;
    assign new_entry = '{module_num:     (fault_in.module_num > `HIST_MAX_MODULE) ? `HIST_MAX_MODULE
                                                                                  : fault_in.module_num,
                         error_register: fault_in.error_register,
                         code:           code_of(fault_in.cause)};

    // a fault in the same cycle as a clear wins, so it is never lost
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            count_q <= `RST_ERROR_COUNT;
            for (int i = 0; i < DEPTH; i++) hist_q[i] <= '0;
        end else if (clk_en_in) begin
            if (fault_valid_in) begin
                hist_q[0] <= new_entry;
                for (int i = 1; i < DEPTH; i++) hist_q[i] <= clear_hist ? '0 : hist_q[i-1];
                count_q <= clear_hist ? 8'h01 : ((count_q < 8'(DEPTH)) ? count_q + 8'h01 : count_q);
            end else if (clear_hist) begin
                count_q <= 8'h00;
                for (int i = 0; i < DEPTH; i++) hist_q[i] <= '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration objects and access answer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync_id_q     <= `RST_SYNC_IDENTIFIER;
            sync_period_q <= `RST_SYNC_CYCLE;
            guard_time_q  <= `RST_GUARD_TIME;
            lifetime_q    <= `RST_LIFETIME_MULT;
            od_done_q     <= 1'b0;
            od_ans_q      <= '0;
        end else if (clk_en_in) begin
            if (wr_sync_id) sync_id_q <= od_req_in.data;
            if (wr_period) sync_period_q <= od_req_in.data;
            if (wr_guard) guard_time_q <= od_req_in.data[15:0];
            if (wr_life) lifetime_q <= od_req_in.data[7:0];
            od_done_q <= od_valid_in;
            if (od_valid_in) begin
                od_ans_q.abort <= od_req_in.write ? !wr_ok : !rd_ok;
                od_ans_q.data  <= od_req_in.write ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // sync frame filter
    // ---------------------------------------------------------------
    // bit 31 takes no part in the match
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync_hit_q <= 1'b0;
        end else if (clk_en_in) begin
            sync_hit_q <= frame_valid_in && (frame_id_in == sync_id_q[`SYNC_ID_MSB:0]);
        end
    end

    // ---------------------------------------------------------------
    // life guarding of the master
    // ---------------------------------------------------------------
    wire [23:0] lifetime_ms = 24'(guard_time_q) * 24'(lifetime_q);
    wire        guard_on    = (lifetime_q != 8'h00) && (guard_time_q != 16'h0000);
    wire        ms_tick     = ms_tick_cnt_q == 32'(MS_CYCLES - 1);

    // millisecond prescaler; counts whenever guard_on is set, restarts on each guard request
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ms_tick_cnt_q <= 32'h0000_0000;
        end else if (clk_en_in) begin
            if (guard_rx_in || !guard_on || ms_tick) ms_tick_cnt_q <= 32'h0000_0000;
            else ms_tick_cnt_q <= ms_tick_cnt_q + 32'h0000_0001;
        end
    end

    // supervision arms on the first guard request; expiry is latched until the next request or until guarding is switched off
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            guard_state_q   <= GUARD_IDLE;
            guard_ms_left_q <= 24'h00_0000;
        end else if (clk_en_in) begin
            case (guard_state_q)
                GUARD_IDLE: begin
                    if (guard_on && guard_rx_in) begin
                        guard_state_q   <= GUARD_ARMED;
                        guard_ms_left_q <= lifetime_ms;
                    end
                end
                GUARD_ARMED: begin
                    if (!guard_on) begin
                        guard_state_q <= GUARD_IDLE;
                    end else if (guard_rx_in) begin
                        guard_ms_left_q <= lifetime_ms;
                    end else if (ms_tick) begin
                        if (guard_ms_left_q <= 24'h00_0001) guard_state_q <= GUARD_EXPIRED;
                        guard_ms_left_q <= guard_ms_left_q - 24'h00_0001;
                    end
                end
                GUARD_EXPIRED: begin
                    if (!guard_on) begin
                        guard_state_q <= GUARD_IDLE;
                    end else if (guard_rx_in) begin
                        guard_state_q   <= GUARD_ARMED;
                        guard_ms_left_q <= lifetime_ms;
                    end
                end
                default: guard_state_q <= GUARD_IDLE;
            endcase
        end
    end

    // outputs
    assign od_done_out          = od_done_q;
    assign od_ans_out           = od_ans_q;
    assign sync_hit_out         = sync_hit_q;
    assign guard_expired_out    = guard_state_q == GUARD_EXPIRED;
    assign guard_timeout_ms_out = lifetime_ms;
    assign sync_period_out      = sync_period_q;

endmodule // comm_objects

// ==== verif/comm_objects_sva.sv ====
// port checker for the communication object block
`timescale 1ns/1ps
// --------------------------------
// checker
// --------------------------------
module comm_objects_sva
    import comm_objects_pkg::*;
(
    // clock, reset, strobes
    input wire logic clk_in, resetn_in, clk_en_in, fault_valid_in, od_valid_in, frame_valid_in, guard_rx_in,
    // request side
    input wire comm_objects_pkg::fault_event_t fault_in,
    input wire comm_objects_pkg::od_request_t  od_req_in,
    input wire logic [10:0]                    frame_id_in,
    // answer side
    input wire logic od_done_out, sync_hit_out, guard_expired_out,
    input wire comm_objects_pkg::od_answer_t   od_ans_out,
    input wire logic [23:0]                    guard_timeout_ms_out,
    input wire logic [31:0]                    sync_period_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // decoded writes; clock enable gates every request
    wire take = od_valid_in && clk_en_in;
    wire wr = take && od_req_in.write;
    wire w_hist = wr && od_req_in.index == 16'h1003;
    wire w_id = wr && od_req_in.index == 16'h1005 && od_req_in.sub_index == 8'h00;
    wire w_str = wr && (od_req_in.index == 16'h1008 || od_req_in.index == 16'h100a);
    AST_DONE_NEXT: assert property (take |=> od_done_out) else $error("no done");
    AST_DONE_ONCE: assert property (clk_en_in && !od_valid_in |=> !od_done_out) else $error("stray done");
    AST_ENTRY_RO: assert property (w_hist && od_req_in.sub_index != 8'h00 |=> od_ans_out.abort)
        else $error("entry written");
    AST_COUNT_WR: assert property (w_hist && od_req_in.sub_index == 8'h00 |=>
        od_ans_out.abort == ($past(od_req_in.data) != 32'h0)) else $error("count write");
    AST_CONST_RO: assert property (w_str |=> od_ans_out.abort) else $error("string written");
    AST_SYNC_FMT: assert property (w_id |=>
        od_ans_out.abort == ($past(od_req_in.data[30:11]) != 20'h0)) else $error("sync id check");
    AST_PERIOD_OK: assert property (sync_period_out == 32'h0 || (sync_period_out >= 32'd10000 &&
        sync_period_out <= 32'd10000000 && sync_period_out % 32'd1000 == 32'h0)) else $error("bad period");
    AST_HIT_CAUSE: assert property ($rose(sync_hit_out) |-> $past(frame_valid_in)) else $error("hit");
    AST_NO_GUARD: assert property (guard_timeout_ms_out == 24'h0 [*3] |-> !guard_expired_out)
        else $error("expired while unsupervised");
    // main scenarios reached
    COV_WRITE: cover property (wr ##1 !od_ans_out.abort);
    COV_HIT: cover property (sync_hit_out);
    COV_EXPIRE: cover property ($rose(guard_expired_out));
endmodule // comm_objects_sva
bind comm_objects comm_objects_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .fault_valid_in(fault_valid_in), .od_valid_in(od_valid_in), .frame_valid_in(frame_valid_in),
    .guard_rx_in(guard_rx_in), .fault_in(fault_in), .od_req_in(od_req_in), .frame_id_in(frame_id_in),
    .od_done_out(od_done_out), .sync_hit_out(sync_hit_out), .guard_expired_out(guard_expired_out),
    .od_ans_out(od_ans_out), .guard_timeout_ms_out(guard_timeout_ms_out), .sync_period_out(sync_period_out));

// ==== verif/guard_master_model.sv ====
// network master model sending node guard requests
`timescale 1ns/1ps
// --------------------------------
// guard source
// --------------------------------
module guard_master_model (
    input  wire logic       clk_in,
    input  wire logic       run_in,  // master guarding
    input  wire logic [7:0] gap_in,  // idle cycles between requests
    output logic            guard_out = 1'b0
);
    logic [7:0] cnt_q = 8'h00;
    // launched off the falling edge so the design samples settled pulses
    always @(negedge clk_in) begin
        cnt_q <= (run_in && cnt_q != gap_in) ? cnt_q + 8'h01 : 8'h00;
        guard_out <= run_in && cnt_q == gap_in;
    end
endmodule // guard_master_model

// ==== verif/tb_top.sv ====
// self-checking bench for the communication object block
`timescale 1ns/1ps
// --------------------------------
// bench
// --------------------------------
module tb_top;
    import comm_objects_pkg::*;
    localparam logic [63:0] NAME = 64'h4e4f44455f583031; // arbitrary
    localparam logic [63:0] VERS = 64'h30312e30302e3030;
    logic clk_in = 0, resetn_in = 0, fault_valid_in = 0, od_valid_in = 0, frame_valid_in = 0, run = 0;
    logic od_done_out, sync_hit_out, guard_rx_in, guard_expired_out;
    logic clk_en_in = 1;
    fault_event_t fault_in = '0;
    od_request_t od_req_in = '0;
    od_answer_t od_ans_out;
    logic [10:0] frame_id_in = 11'h000;
    logic [23:0] guard_timeout_ms_out;
    logic [31:0] sync_period_out, exp_e, prev_e;
    logic [15:0] codes [19] = '{16'h0000, 16'h0080, 16'h1000, 16'h6101, 16'h6102, 16'h7001, 16'h7002,
        16'h7003, 16'h8110, 16'h8120, 16'h8130, 16'h8140, 16'h8210, 16'h8250, 16'hf001, 16'hff01, 16'hff02,
        16'hff03, 16'hff04};
    logic [15:0] rix [5] = '{16'h1003, 16'h1005, 16'h1006, 16'h100c, 16'h100d};
    logic [31:0] pv [6] = '{32'h0, 32'd9000, 32'd10000, 32'd10500, 32'd10001000, 32'd10000000};
    logic pa [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int n_fail = 0, checks_done = 0, cyc = 0;
    always #50 clk_in = ~clk_in;
    comm_objects #(.MS_CYCLES(4), .NAME_STRING(NAME), .VERSION_STR(VERS)) u_dut (.clk_in(clk_in),
        .resetn_in(resetn_in), .clk_en_in(clk_en_in), .fault_valid_in(fault_valid_in), .fault_in(fault_in),
        .od_valid_in(od_valid_in), .od_req_in(od_req_in), .od_done_out(od_done_out), .od_ans_out(od_ans_out),
        .frame_valid_in(frame_valid_in), .frame_id_in(frame_id_in), .sync_hit_out(sync_hit_out),
        .guard_rx_in(guard_rx_in), .guard_expired_out(guard_expired_out),
        .guard_timeout_ms_out(guard_timeout_ms_out), .sync_period_out(sync_period_out));
    guard_master_model u_master (.clk_in(clk_in), .run_in(run), .gap_in(8'h01), .guard_out(guard_rx_in));
    task check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held over one sampling edge, answer read half a cycle after it
    task acc(logic w, logic [15:0] ix, logic [7:0] sub, logic [31:0] d, logic ab, logic [31:0] rd);
        @(negedge clk_in);
        od_valid_in = 1;
        od_req_in = '{w, ix, sub, d};
        @(negedge clk_in);
        od_valid_in = 0;
        check("done", 32'(od_done_out), 32'h1);
        check("abort", 32'(od_ans_out.abort), 32'(ab));
        if (!w) check("data", od_ans_out.data, rd);
    endtask
    // one frame; the hit pulse is looked at in its only cycle
    task frame(logic [10:0] id, logic hit);
        @(negedge clk_in);
        frame_valid_in = 1;
        frame_id_in = id;
        @(negedge clk_in);
        frame_valid_in = 0;
        check("sync hit", 32'(sync_hit_out), 32'(hit));
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // main sequence: reset values, history, clear, sync, period, strings, guarding
    initial begin
        repeat (16) @(negedge clk_in);
        resetn_in = 1;
        for (int i = 0; i < 5; i++) acc(0, rix[i], 0, 0, 0, (i == 1) ? 32'h80 : 32'h0);
        acc(0, 16'h1004, 0, 0, 1, 0);
        prev_e = 0;
        for (int i = 0; i < 19; i++) begin
            @(negedge clk_in);
            fault_valid_in = 1;
            fault_in = '{fault_cause_t'(i), 8'(i), 8'(8'ha0 + i)};
            @(negedge clk_in);
            fault_valid_in = 0;
            exp_e = {(i > 14) ? 8'h0e : 8'(i), 8'(8'ha0 + i), codes[i]};
            acc(0, 16'h1003, 1, 0, 0, exp_e);
            if (i > 0) acc(0, 16'h1003, 2, 0, 0, prev_e);
            acc(0, 16'h1003, 0, 0, 0, (i < 10) ? 32'(i + 1) : 32'd10);
            prev_e = exp_e;
        end
        acc(0, 16'h1003, 10, 0, 0, {8'h09, 8'ha9, 16'h8120});
        acc(0, 16'h1003, 11, 0, 1, 0);
        acc(1, 16'h1003, 1, 0, 1, 0);
        acc(1, 16'h1003, 0, 5, 1, 0);
        acc(1, 16'h1003, 0, 0, 0, 0);
        acc(0, 16'h1003, 0, 0, 0, 0);
        // fault and clear in one cycle: the fault survives alone
        @(negedge clk_in);
        fault_valid_in = 1;
        od_valid_in = 1;
        od_req_in = '{1'b1, 16'h1003, 8'h00, 32'h0};
        @(negedge clk_in);
        fault_valid_in = 0;
        od_valid_in = 0;
        acc(0, 16'h1003, 0, 0, 0, 32'h1);
        acc(0, 16'h1003, 1, 0, 0, {8'h0e, 8'hb2, 16'hff04});
        acc(0, 16'h1003, 2, 0, 0, 0);
        acc(1, 16'h1005, 0, 32'h4000_0080, 1, 0);
        acc(1, 16'h1005, 0, 32'h2000_0080, 1, 0);
        acc(1, 16'h1005, 0, 32'h0000_0880, 1, 0);
        acc(1, 16'h1005, 0, 32'h8000_0123, 0, 0);
        acc(0, 16'h1005, 0, 0, 0, 32'h8000_0123);
        frame(11'h123, 1);
        frame(11'h124, 0);
        exp_e = 0;
        for (int i = 0; i < 6; i++) begin
            acc(1, 16'h1006, 0, pv[i], pa[i], 0);
            @(negedge clk_in);
            if (!pa[i]) exp_e = pv[i];
            check("period", sync_period_out, exp_e);
        end
        for (int i = 0; i < 2; i++) begin
            acc(0, 16'h1008, 0, 32'(i), 0, NAME[32*i +: 32]);
            acc(0, 16'h100a, 0, 32'(i), 0, VERS[32*i +: 32]);
        end
        acc(1, 16'h1008, 0, 0, 1, 0);
        acc(1, 16'h100a, 0, 0, 1, 0);
        acc(1, 16'h100c, 0, 1, 0, 0);
        acc(1, 16'h100d, 0, 2, 0, 0);
        check("timeout", 32'(guard_timeout_ms_out), 32'h2);
        run <= 1;
        repeat (40) @(negedge clk_in);
        check("alive", 32'(guard_expired_out), 32'h0);
        run <= 0;
        repeat (30) @(negedge clk_in);
        check("expired", 32'(guard_expired_out), 32'h1);
        acc(1, 16'h100d, 0, 0, 0, 0);
        repeat (4) @(negedge clk_in);
        check("idle", 32'(guard_expired_out), 32'h0);
        // a request while the clock enable is low leaves no trace
        @(negedge clk_in);
        clk_en_in = 0;
        od_valid_in = 1;
        od_req_in = '{1'b1, 16'h100d, 8'h00, 32'h5};
        @(negedge clk_in);
        od_valid_in = 0;
        clk_en_in = 1;
        check("frozen done", 32'(od_done_out), 32'h0);
        acc(0, 16'h100d, 0, 0, 0, 32'h0);
        summarize();
    end
endmodule // tb_top
